// >>> design/rotfill_datapath.v
// Rotate and fill datapath slice with four-phase instruction cycle
// Function
// RULE_01: Rotate left without carry: bit7 to bit0, update N and Z, one cycle.
// RULE_02: Rotate right through carry: C to bit7, bit0 to C, update C,N,Z.
// RULE_03: Rotate right without carry: bit0 to bit7, carry kept, update N,Z.
// RULE_04: Fill writes all ones to file register only; flags unchanged; one cycle.
// RULE_05: Destination bit 1 writes result back to the source file register.
// RULE_06: Destination bit 0 writes result to working register only.
// RULE_07: Access bit 0 selects fixed access bank, ignoring bank select register.
// RULE_08: Access bit 1 forms address from bank select register and file field.
// RULE_09: Phases: decode, read file register, compute, write destination.
`timescale 1ns/100ps
`default_nettype none
`include "rotfill_defs.vh"
module rotfill_datapath (
   input wire mclk,
   input wire reset_n,
   input wire instr_valid,
   input wire [15:0] instr_word,
   input wire [3:0] bank_select_register,
   input wire [7:0] mem_rd_data,
   output reg [11:0] mem_addr,
   output reg mem_rd_en,
   output reg mem_wr_en,
   output reg [7:0] mem_wr_data,
   output reg [7:0] working_register,
   output reg [4:0] status_flags,
   output reg busy,
   output reg illegal_op
);
   // ----------------------------------------
   // Phase encoding
   // ----------------------------------------
   localparam PH_IDLE = 5'h01;
   localparam PH_Q1 = 5'h02;
   localparam PH_Q2 = 5'h04;
   localparam PH_Q3 = 5'h08;
   localparam PH_Q4 = 5'h10;

   function [11:0] form_addr;
      input acc;
      input [3:0] bank;
      input [7:0] file;
      begin
         if (acc)
            form_addr = {bank, file}; // RULE_08
         else if (file < `ACCESS_SPLIT)
            form_addr = {4'h0, file}; // RULE_07
         else
            form_addr = {`ACCESS_HI_BANK, file}; // RULE_07
      end
   endfunction

   reg [4:0] phase_r;
   reg [15:0] instr_r;
   reg [1:0] op_r;
   reg [7:0] operand_r;
   reg [7:0] result_r;
   reg carry_r;
   wire [7:0] unit_result;
   wire unit_carry;
   wire is_fill = (instr_r[15:9] == `OP_FILL_HI);
   wire is_rlnc = (instr_r[15:10] == `OP_RLNC_HI);
   wire is_rrc = (instr_r[15:10] == `OP_RRC_HI);
   wire is_rrnc = (instr_r[15:10] == `OP_RRNC_HI);
   wire known = is_fill | is_rlnc | is_rrc | is_rrnc;
   wire [11:0] addr_nxt = form_addr(instr_r[`F_ACC], bank_select_register, instr_r[7:0]);
   wire to_file = is_fill | instr_r[`F_DEST]; // RULE_04

   rotfill_unit u_unit (
      .op_sel(op_r),
      .operand(operand_r),
      .carry_in(status_flags[`FLAG_C]),
      .result(unit_result),
      .carry_out(unit_carry)
   );

   // ----------------------------------------
   // Phase sequencer and datapath
   // ----------------------------------------
   always @(posedge mclk) begin
      if (!reset_n) begin
         phase_r <= PH_IDLE;
         instr_r <= 16'h0000;
         op_r <= 2'h0;
         operand_r <= 8'h00;
         result_r <= 8'h00;
         carry_r <= 1'b0;
         mem_addr <= 12'h000;
         mem_rd_en <= 1'b0;
         mem_wr_en <= 1'b0;
         mem_wr_data <= 8'h00;
         working_register <= 8'h00;
         status_flags <= `STATUS_RESET;
         busy <= 1'b0;
         illegal_op <= 1'b0;
      end else begin
         mem_rd_en <= 1'b0;
         mem_wr_en <= 1'b0;
         illegal_op <= 1'b0;
         case (phase_r)
            PH_IDLE: begin
               if (instr_valid) begin
                  instr_r <= instr_word;
                  busy <= 1'b1;
                  phase_r <= PH_Q1;
               end
            end
            PH_Q1: begin
               // Decode
               if (known) begin
                  op_r <= is_rlnc ? 2'h0 : is_rrc ? 2'h1 : is_rrnc ? 2'h2 : 2'h3; // RULE_09
                  mem_addr <= addr_nxt;
                  mem_rd_en <= 1'b1;
                  phase_r <= PH_Q2;
               end else begin
                  illegal_op <= 1'b1;
                  busy <= 1'b0;
                  phase_r <= PH_IDLE;
               end
            end
            PH_Q2: begin
               operand_r <= mem_rd_data; // RULE_09
               phase_r <= PH_Q3;
            end
            PH_Q3: begin
               result_r <= unit_result; // RULE_09
               carry_r <= unit_carry;
               phase_r <= PH_Q4;
            end
            PH_Q4: begin
               if (to_file) begin
                  mem_wr_en <= 1'b1; // RULE_05
                  mem_wr_data <= result_r;
               end else begin
                  working_register <= result_r; // RULE_06
               end
               if (!is_fill) begin
                  status_flags[`FLAG_N] <= result_r[7]; // RULE_01
                  status_flags[`FLAG_Z] <= (result_r == 8'h00); // RULE_03
                  if (is_rrc)
                     status_flags[`FLAG_C] <= carry_r; // RULE_02
               end
               busy <= 1'b0;
               phase_r <= PH_IDLE;
            end
            default: phase_r <= PH_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> design/rotfill_defs.vh
// Opcode encodings, field positions, access bank constants, fill value and flag positions for the rotate and fill datapath
`ifndef ROTFILL_DEFS_VH
`define ROTFILL_DEFS_VH
`define OP_RLNC_HI 6'h11
`define OP_RRC_HI 6'h0c
`define OP_RRNC_HI 6'h10
`define OP_FILL_HI 7'h34
`define F_DEST 9
`define F_ACC 8
`define F_FILE_HI 7
`define ACCESS_SPLIT 8'h80
`define ACCESS_HI_BANK 4'hf
`define FILL_VALUE 8'hff
`define FLAG_C 0
`define FLAG_Z 2
`define FLAG_N 4
`define STATUS_RESET 5'h00
`endif

// >>> design/rotfill_unit.v
// Combinational rotate and fill result unit
`timescale 1ns/100ps
`default_nettype none
module rotfill_unit (
   input wire [1:0] op_sel,
   input wire [7:0] operand,
   input wire carry_in,
   output reg [7:0] result,
   output reg carry_out
);
   always @* begin
      carry_out = carry_in;
      case (op_sel)
         2'h0: result = {operand[6:0], operand[7]}; // RULE_01
         2'h1: begin
            result = {carry_in, operand[7:1]}; // RULE_02
            carry_out = operand[0]; // RULE_02
         end
         2'h2: result = {operand[0], operand[7:1]}; // RULE_03
         default: result = `FILL_VALUE; // RULE_04
      endcase
   end
endmodule
`default_nettype wire

// >>> sim/rotfill_datapath_props.sv
// Port assertions for the rotate and fill datapath
`timescale 1ns/100ps
`default_nettype none
module rotfill_props (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic [3:0] bank_select_register,
   input wire logic illegal_op,
   input wire logic [11:0] mem_addr,
   input wire logic mem_rd_en,
   input wire logic mem_wr_en,
   input wire logic [4:0] status_flags,
   input wire logic busy
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic [15:0] op_r;
   wire take = instr_valid && !busy;
   wire fill = op_r[15:9] == 7'h34;
   wire legal_in = instr_word[15:10] == 6'h11 || instr_word[15:10] == 6'h0c ||
      instr_word[15:10] == 6'h10 || instr_word[15:9] == 7'h34;
   always @(posedge mclk) if (take) op_r <= instr_word;
   a_busy_span: assert property (take && legal_in |=> busy [*4] ##1 !busy)
      else $error("span");
   a_read_slot: assert property (take && legal_in |-> ##2 mem_rd_en) else $error("read");
   a_illegal_slot: assert property (take && !legal_in |-> ##2 illegal_op)
      else $error("illegal");
   a_bank_reg: assert property ($rose(mem_rd_en) && op_r[8] |->
      mem_addr == {$past(bank_select_register), op_r[7:0]}) else $error("bank select");
   a_wr_slot: assert property (mem_wr_en |-> $past(mem_rd_en, 3)) else $error("wr");
   a_fill_file: assert property ($fell(busy) && fill |-> mem_wr_en) else $error("fill");
   a_fill_flags: assert property (fill && mem_wr_en |-> $stable(status_flags))
      else $error("flags");
   a_dest_file: assert property ($fell(busy) && op_r[9] |-> mem_wr_en)
      else $error("dest");
   a_dest_working_register: assert property ($fell(busy) && !fill && !op_r[9] |-> !mem_wr_en)
      else $error("working_register");
   a_carry_kept: assert property ($fell(busy) && op_r[14] |-> $stable(status_flags[0]))
      else $error("carry");
   a_access_bank: assert property ($rose(mem_rd_en) && !op_r[8] |->
      mem_addr == {{4{op_r[7]}}, op_r[7:0]}) else $error("bank");
endmodule
bind rotfill_datapath rotfill_props chk (.*);
`default_nettype wire

// >>> sim/mem_model.sv
// Data memory model beside the datapath
`timescale 1ns/100ps
`default_nettype none
module mem_model (
   input wire logic mclk,
   input wire logic [11:0] mem_addr,
   input wire logic mem_rd_en,
   input wire logic mem_wr_en,
   input wire logic [7:0] mem_wr_data,
   output logic [7:0] mem_rd_data
);
   logic [7:0] mem [0:4095];
   always @(posedge mclk) if (mem_wr_en) mem[mem_addr] <= mem_wr_data;
   assign mem_rd_data = mem_rd_en ? mem[mem_addr] : ~mem[mem_addr];
endmodule
`default_nettype wire

// >>> sim/rotfill_datapath_bench.sv
// Self-checking bench for the rotate and fill datapath
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) cmp_count++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t value mismatch", $time); end
module rotfill_datapath_bench;
   logic mclk = 0, reset_n = 0, instr_valid = 0, mem_rd_en, mem_wr_en, busy, illegal_op;
   logic [15:0] instr_word = 0;
   logic [3:0] bank_select_register = 0;
   logic [7:0] mem_rd_data, mem_wr_data, working_register, v, r, ew = 0;
   logic [11:0] mem_addr, ea;
   logic [4:0] status_flags, es = 0;
   logic [31:0] s = 75203;
   int miscompares = 0, cmp_count = 0, k, op;
   always #2.5 mclk = ~mclk;
   rotfill_datapath uut (.*);
   mem_model pm (.*);
   function automatic logic [31:0] lf(logic [31:0] x);
      return {x[30:0], ^(x & 32'h80200003)};
   endfunction
   task automatic report_and_stop;
      $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #9000 miscompares++;
      report_and_stop;
   end
   initial begin
      repeat (20) @(posedge mclk);
      reset_n <= 1;
      repeat (60) begin
         s = lf(s);
         op = s[1:0];
         v = s[23:16];
         ea = s[3] ? s[15:4] : {{4{s[11]}}, s[11:4]};
         pm.mem[ea] = v;
         r = op == 0 ? {v[6:0], v[7]} : op == 1 ? {es[0], v[7:1]} : {v[0], v[7:1]};
         if (op == 3) r = 8'hff;
         if (op == 1) es[0] = v[0];
         if (op != 3) es[4:2] = {r[7], 1'b0, r == 0};
         if (op != 3 && !s[2]) ew = r;
         @(posedge mclk) instr_valid <= 1;
         bank_select_register <= s[15:12];
         instr_word <= {op == 3 ? 7'h34 : {op == 0 ? 6'h11 : op == 1 ? 6'h0c : 6'h10, s[2]},
            s[3], s[11:4]};
         repeat (2) @(posedge mclk) instr_valid <= 0;
         for (k = 0; k < 9 && busy !== 1'b0; k++) @(posedge mclk);
         #1 `CHK(pm.mem[ea], op == 3 || s[2] ? r : v)
         `CHK(working_register, ew)
         `CHK(status_flags, es)
      end
      @(posedge mclk) instr_valid <= 1;
      instr_word <= 16'h0000;
      @(posedge mclk) instr_valid <= 0;
      @(posedge mclk) #1 `CHK(illegal_op, 1'b1)
      `CHK(busy, 1'b0)
      report_and_stop;
   end
endmodule
`default_nettype wire
